// ===== tb.sv
// Purpose: Self-checking bench for the fault override block.
// Assumes: Interrupt enable bit0 is kept on through the mode loop.
// Notes: All eight control mode combinations are visited with random data.
`timescale 1ns/10ps
`include "wfo_regs.svh"
module tb;
	logic                   clk = 0, rst = 1, wr = 0, rd = 0, fault = 0, upd = 0;
	logic [`WFO_ADDR_W-1:0] addr = '0;
	logic [7:0]             wdata = '0, wave = '0, port = '0, rdata, pins, sw, d, ov, ctl;
	logic                   irq;
	logic [3:0]             dead_time_insertion;
	int                     errors = 0, tests_run = 0;
	logic [31:0]            seed = 32'h6BAC244D, r;
	always #2.5 clk = ~clk;
	wfo_fault_override wfo_fault_override_inst (.mclk_in(clk), .sys_rst_in(rst),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .fault_in(fault), .update_in(upd), .wave_in(wave),
		.port_in(port), .pin_out(pins), .irq_out(irq));
	wfo_power_stage wfo_power_stage_inst (.mclk_in(clk), .gate_in(pins), .sw_out(sw));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Pattern mode takes the buffer whole; otherwise each channel opens its pin pair.
	function automatic logic [7:0] restore(input logic [7:0] c, input logic [3:0] e,
		input logic [7:0] b);
		logic [7:0] x;
		x = '0;
		for (int g = 0; g < 4; g++) x[2*g +: 2] = {2{e[g]}};
		return c[0] ? b : x;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// The stage lags the pins by one clock, so both are read once settled.
	task automatic chk_pins(input logic [7:0] o);
		repeat (3) @(posedge clk);
		#1;
		chk(pins, (o & wave) | (~o & port));
		chk(sw, (o & wave) | (~o & port));
	endtask
	task automatic test_done;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		test_done;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 4; a++) begin
			rreg(a[3:0], d);
			chk(d, 8'h00);
		end
		wreg(`WFO_INTEN_ADDR, 8'h01);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			r = seed;
			ctl = 8'h08 | 8'(i);
			dead_time_insertion = r[19:16] | 4'h1;
			wave <= r[7:0];
			port <= r[15:8];
			wreg(`WFO_CTRL_ADDR, ctl);
			wreg(`WFO_DTIEN_ADDR, {4'h0, dead_time_insertion});
			wreg(`WFO_LSBUF_ADDR, r[31:24] | 8'h01);
			wreg(`WFO_OVEN_ADDR, r[23:16]);
			rreg(`WFO_OVEN_ADDR, d);
			chk(d, r[23:16]);
			chk_pins(r[23:16]);
			@(posedge clk) fault <= 1'b1;
			repeat (3) @(posedge clk);
			rreg(`WFO_OVEN_ADDR, d);
			chk(d, 8'h00);
			chk({7'h0, irq}, 8'h01);
			chk_pins(8'h00);
			rreg(`WFO_LIVE_ADDR, d);
			chk(d & 8'h04, 8'h04);
			@(posedge clk) fault <= 1'b0;
			repeat (3) @(posedge clk);
			if (ctl[2]) begin
				rreg(`WFO_OVEN_ADDR, d);
				chk(d, 8'h00);
				if (i[0]) begin
					wreg(`WFO_INTEN_ADDR, 8'h01);
				end else begin
					@(posedge clk) upd <= 1'b1;
					@(posedge clk) upd <= 1'b0;
				end
				repeat (2) @(posedge clk);
			end
			ov = restore(ctl, dead_time_insertion, r[31:24] | 8'h01);
			rreg(`WFO_OVEN_ADDR, d);
			chk(d, ov);
			chk_pins(ov);
			rreg(`WFO_STAT_ADDR, d);
			chk(d, 8'h03);
			wreg(`WFO_INTCLR_ADDR, 8'h07);
			@(posedge clk);
			#1 chk({7'h0, irq}, 8'h00);
		end
		// An unmapped read answers zero and flags itself, seen only once unmasked.
		wreg(`WFO_INTEN_ADDR, 8'h00);
		rreg(4'hF, d);
		chk(d, 8'h00);
		chk({7'h0, irq}, 8'h00);
		wreg(`WFO_INTEN_ADDR, 8'h04);
		@(posedge clk);
		#1 chk({7'h0, irq}, 8'h01);
		rreg(`WFO_STAT_ADDR, d);
		chk(d & 8'h04, 8'h04);
		test_done;
	end
endmodule // tb

// ===== wfo_fault_override.sv
// Purpose: Fault protection and override restore for a waveform extension.
// Assumes: 8-bit register port with read data one cycle after the read strobe.
// Notes: Fault input is a synchronous level; update is a one-cycle pulse.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "wfo_regs.svh"
module wfo_fault_override (
	// Clock and reset
	input  wire logic                   mclk_in,
	input  wire logic                   sys_rst_in,
	// Register port
	input  wire logic [`WFO_ADDR_W-1:0] reg_addr_in,
	input  wire logic [7:0]             reg_wdata_in,
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	output logic      [7:0]             reg_rdata_out,
	// Waveform side
	input  wire logic                   fault_in,
	input  wire logic                   update_in,
	input  wire logic [7:0]             wave_in,
	input  wire logic [7:0]             port_in,
	// Pins and interrupt
	output logic      [7:0]             pin_out,
	output logic                        irq_out
);
	logic [7:0]          ctrl_q;
	logic [7:0]          oven_q;
	logic [7:0]          oven_d;
	logic [`WFO_NCH-1:0] dti_en_q;
	logic [7:0]          lsbuf_q;
	logic [2:0]          stat_q;
	logic [2:0]          stat_d;
	logic [2:0]          inten_q;
	logic [7:0]          rdata_q;
	wfo_pkg::prot_state_t st_q;
	wfo_pkg::prot_state_t st_d;
	wfo_pkg::wave_mode_t  mode;
	logic [7:0]          restore;
	logic                fault_on;
	logic                fault_rise;
	logic                restore_now;
	logic                fault_prev_q;
	logic                addr_mapped;
	logic [7:0]          rd_mux;
	logic                wr_ctrl;
	logic                wr_oven;
	logic                wr_dtien;
	logic                wr_lsbuf;
	logic                wr_inten;
	logic                wr_intclr;
	logic                bus_unmapped;
	logic [7:0]          exp_restore;

	function automatic logic is_addr(input logic [`WFO_ADDR_W-1:0] a,
	                                 input logic [`WFO_ADDR_W-1:0] b);
		return a == b;
	endfunction

	// Each dead-time channel owns one low/high pin pair, so its enable opens both.
	function automatic logic [7:0] pair_mask(input logic [`WFO_NCH-1:0] ch);
		logic [7:0] m;
		m = 8'h00;
		for (int k = 0; k < `WFO_NCH; k++) begin
			m[2*k]   = ch[k];
			m[2*k+1] = ch[k];
		end
		return m;
	endfunction

	// Table of modes: pattern bit wins, common mode only without it.
	assign mode = ctrl_q[`WFO_CTRL_PGM_BIT]  ? wfo_pkg::WAVE_PATTERN :
	              ctrl_q[`WFO_CTRL_COMMON_WAVEFORM_CHANNEL_MODE_BIT] ? wfo_pkg::WAVE_COMMON : wfo_pkg::WAVE_PLAIN;
	assign fault_on   = fault_in & ctrl_q[`WFO_CTRL_FEN_BIT];
	assign fault_rise = fault_on & ~fault_prev_q;
	assign addr_mapped = (reg_addr_in <= `WFO_LIVE_ADDR);

	assign wr_ctrl      = reg_wr_in & is_addr(reg_addr_in, `WFO_CTRL_ADDR);
	assign wr_oven      = reg_wr_in & is_addr(reg_addr_in, `WFO_OVEN_ADDR);
	assign wr_dtien     = reg_wr_in & is_addr(reg_addr_in, `WFO_DTIEN_ADDR);
	assign wr_lsbuf     = reg_wr_in & is_addr(reg_addr_in, `WFO_LSBUF_ADDR);
	assign wr_inten     = reg_wr_in & is_addr(reg_addr_in, `WFO_INTEN_ADDR);
	assign wr_intclr    = reg_wr_in & is_addr(reg_addr_in, `WFO_INTCLR_ADDR);
	assign bus_unmapped = (reg_wr_in | reg_rd_in) & ~addr_mapped;

	// Kept apart from the selector so the checks below do not share its logic.
	assign exp_restore = ctrl_q[`WFO_CTRL_PGM_BIT] ? lsbuf_q : pair_mask(dti_en_q);

	wfo_restore_sel u_sel (
		.mode_in     (mode),
		.dti_en_in   (dti_en_q),
		.lsbuf_in    (lsbuf_q),
		.restore_out (restore)
	);

	// Restore happens when the fault is gone: at once, or in cycle-by-cycle mode on an update or any software write.
	always_comb begin
		st_d = st_q;
		restore_now = 1'b0;
		case (st_q)
			wfo_pkg::PROT_RUN: begin
				if (fault_on) st_d = wfo_pkg::PROT_TRIPPED;
			end
			wfo_pkg::PROT_TRIPPED: begin
				if (!fault_on) begin
					if (reg_wr_in) begin
						restore_now = 1'b1;
						st_d = wfo_pkg::PROT_RUN;
					end else if (ctrl_q[`WFO_CTRL_CBC_BIT]) begin
						st_d = wfo_pkg::PROT_WAIT_UPDATE;
					end else begin
						restore_now = 1'b1;
						st_d = wfo_pkg::PROT_RUN;
					end
				end
			end
			wfo_pkg::PROT_WAIT_UPDATE: begin
				if (fault_on) st_d = wfo_pkg::PROT_TRIPPED;
				else if (update_in || reg_wr_in) begin
					restore_now = 1'b1;
					st_d = wfo_pkg::PROT_RUN;
				end
			end
			default: st_d = wfo_pkg::PROT_RUN;
		endcase
	end

	// Fault clearing outranks any software write to the enables.
	always_comb begin
		oven_d = oven_q;
		if (wr_oven) oven_d = reg_wdata_in;
		if (restore_now) oven_d = restore;
		if (fault_on) oven_d = 8'h00;
	end

	// Sticky events: set wins over a clear in the same cycle.
	always_comb begin
		stat_d = stat_q;
		if (wr_intclr) stat_d = stat_q & ~reg_wdata_in[2:0];
		if (fault_rise) stat_d[`WFO_ST_FAULT_BIT] = 1'b1;
		if (restore_now) stat_d[`WFO_ST_REST_BIT] = 1'b1;
		if (bus_unmapped) stat_d[`WFO_ST_UNMAP_BIT] = 1'b1;
	end

	always_comb begin
		rd_mux = 8'h00;
		case (reg_addr_in)
			`WFO_CTRL_ADDR:  rd_mux = ctrl_q;
			`WFO_OVEN_ADDR:  rd_mux = oven_q;
			`WFO_DTIEN_ADDR: rd_mux = {4'h0, dti_en_q};
			`WFO_LSBUF_ADDR: rd_mux = lsbuf_q;
			`WFO_STAT_ADDR:  rd_mux = {5'h00, stat_q};
			`WFO_INTEN_ADDR: rd_mux = {5'h00, inten_q};
			`WFO_LIVE_ADDR:  rd_mux = {5'h00, fault_on, st_q};
			default:         rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			st_q         <= wfo_pkg::PROT_RUN;
			oven_q       <= `WFO_OVEN_RST;
			stat_q       <= 3'h0;
			fault_prev_q <= 1'b0;
			rdata_q      <= 8'h00;
		end else begin
			st_q         <= st_d;
			oven_q       <= oven_d;
			stat_q       <= stat_d;
			fault_prev_q <= fault_on;
			rdata_q      <= reg_rd_in ? rd_mux : 8'h00;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			ctrl_q   <= `WFO_CTRL_RST;
			dti_en_q <= 4'h0;
			lsbuf_q  <= `WFO_LSBUF_RST;
			inten_q  <= 3'h0;
		end else begin
			if (wr_ctrl)  ctrl_q   <= reg_wdata_in;
			if (wr_dtien) dti_en_q <= reg_wdata_in[3:0];
			if (wr_lsbuf) lsbuf_q  <= reg_wdata_in;
			if (wr_inten) inten_q  <= reg_wdata_in[2:0];
		end
	end

	assign reg_rdata_out = rdata_q;
	assign irq_out = |(stat_q & inten_q);

	wfo_pin_mux u_mux (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.oven_in    (oven_q),
		.wave_in    (wave_in),
		.port_in    (port_in),
		.pin_out    (pin_out)
	);

	AST_FAULT_CLEARS: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		fault_on |=> (oven_q == 8'h00))
		else $error("Override enables not cleared on fault.");
	AST_RESTORE_DTI: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(st_q == wfo_pkg::PROT_TRIPPED && !fault_on && !ctrl_q[`WFO_CTRL_CBC_BIT]
		 && mode != wfo_pkg::WAVE_PATTERN && !reg_wr_in)
		|=> (oven_q == pair_mask($past(dti_en_q))))
		else $error("Restore did not follow dead-time channels.");
	AST_RESTORE_PGM: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(restore_now && !fault_on && mode == wfo_pkg::WAVE_PATTERN) |=> (oven_q == $past(lsbuf_q)))
		else $error("Pattern mode restore not from low-side buffer.");
	AST_CBC_UPDATE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(st_q == wfo_pkg::PROT_WAIT_UPDATE && update_in && !fault_on)
		|=> (st_q == wfo_pkg::PROT_RUN && oven_q == $past(exp_restore)))
		else $error("Cycle-by-cycle restore missed the update.");
	AST_WRITE_REENABLE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(st_q != wfo_pkg::PROT_RUN && !fault_on && reg_wr_in) |=> (st_q == wfo_pkg::PROT_RUN))
		else $error("Register write did not re-enable outputs.");
	AST_PIN_SELECT: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		1'b1 |=> (pin_out == (($past(oven_q) & $past(wave_in)) | (~$past(oven_q) & $past(port_in)))))
		else $error("Pin did not follow override selection.");
	AST_STAY_TRIPPED: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(fault_on [*2]) |-> (st_q == wfo_pkg::PROT_TRIPPED && oven_q == 8'h00))
		else $error("Block left tripped state during fault.");
	AST_IRQ_FAULT: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(fault_rise && inten_q[`WFO_ST_FAULT_BIT]) |=> irq_out)
		else $error("Fault event did not raise the interrupt.");

	// Protection sequence: no restore may slip in while the fault stands.
	AST_NO_EARLY_REST: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		fault_on
		|-> !restore_now)
		else $error("Restore fired while the fault was present.");
	AST_TRIP_ENTRY: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(st_q == wfo_pkg::PROT_RUN && fault_on)
		|=> (st_q == wfo_pkg::PROT_TRIPPED && oven_q == 8'h00))
		else $error("Fault did not trip the protection.");
	AST_TRIP_HOLD: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(st_q == wfo_pkg::PROT_TRIPPED && fault_on)
		|=> (st_q == wfo_pkg::PROT_TRIPPED && oven_q == 8'h00))
		else $error("Tripped state not held during fault.");
	AST_REFAULT_WAIT: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(st_q == wfo_pkg::PROT_WAIT_UPDATE && fault_on)
		|=> (st_q == wfo_pkg::PROT_TRIPPED))
		else $error("New fault while waiting did not trip again.");
	AST_PINS_IN_FAULT: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(fault_on [*2])
		|=> (pin_out == $past(port_in)))
		else $error("Pins still carry the waveform during fault.");
	AST_NONCBC_RUN: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(st_q == wfo_pkg::PROT_TRIPPED && !fault_on && !ctrl_q[`WFO_CTRL_CBC_BIT])
		|=> (st_q == wfo_pkg::PROT_RUN))
		else $error("Restore did not follow the end of the fault.");
	AST_CBC_WAITS: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(st_q == wfo_pkg::PROT_TRIPPED && !fault_on && ctrl_q[`WFO_CTRL_CBC_BIT] && !reg_wr_in)
		|=> (st_q == wfo_pkg::PROT_WAIT_UPDATE && oven_q == 8'h00))
		else $error("Cycle-by-cycle restore did not wait for an update.");
	AST_WAIT_HOLDS: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(st_q == wfo_pkg::PROT_WAIT_UPDATE && !fault_on && !update_in && !reg_wr_in)
		|=> (st_q == wfo_pkg::PROT_WAIT_UPDATE && oven_q == 8'h00))
		else $error("Outputs resumed before an update.");
	AST_WRITE_VALUE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(st_q != wfo_pkg::PROT_RUN && !fault_on && reg_wr_in)
		|=> (oven_q == $past(exp_restore)))
		else $error("Write restore gave the wrong enables.");

	// Register port and enable storage.
	AST_OVEN_WRITE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(wr_oven && !fault_on && !restore_now)
		|=> (oven_q == $past(reg_wdata_in)))
		else $error("Override enable write was lost.");
	AST_RUN_KEEPS: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(st_q == wfo_pkg::PROT_RUN && !fault_on && !wr_oven)
		|=> (oven_q == $past(oven_q)))
		else $error("Override enables changed without cause.");
	AST_RDATA_IDLE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		!reg_rd_in
		|=> (reg_rdata_out == 8'h00))
		else $error("Read data not zero outside a read.");
	AST_RDATA_OVEN: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(reg_rd_in && is_addr(reg_addr_in, `WFO_OVEN_ADDR))
		|=> (reg_rdata_out == $past(oven_q)))
		else $error("Override enable read returned a wrong value.");

	// Sticky status flags: set wins over clear.
	AST_FLAG_FAULT: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		fault_rise
		|=> stat_q[`WFO_ST_FAULT_BIT])
		else $error("Fault flag not set.");
	AST_FLAG_UNMAP: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		bus_unmapped
		|=> stat_q[`WFO_ST_UNMAP_BIT])
		else $error("Unmapped access flag not set.");
	AST_FLAG_STICKY: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(stat_q[`WFO_ST_FAULT_BIT] && !wr_intclr)
		|=> stat_q[`WFO_ST_FAULT_BIT])
		else $error("Fault flag dropped without a clear.");
	AST_FLAG_CLEAR: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(wr_intclr && reg_wdata_in[`WFO_ST_FAULT_BIT] && !fault_rise)
		|=> !stat_q[`WFO_ST_FAULT_BIT])
		else $error("Fault flag not cleared by a write.");
endmodule // wfo_fault_override

// ===== wfo_pin_mux.sv
// Purpose: Per-pin selection between waveform and port function.
// Assumes: All inputs are synchronous to mclk_in.
// Notes: Registered so pins do not glitch during override changes.
`timescale 1ns/10ps
module wfo_pin_mux (
	// Clock and reset
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	// Selection
	input  wire logic [7:0] oven_in,
	input  wire logic [7:0] wave_in,
	input  wire logic [7:0] port_in,
	// Pins
	output logic      [7:0] pin_out
);
	logic [7:0] pin_d;
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			assign pin_d[g] = oven_in[g] ? wave_in[g] : port_in[g];
		end
	endgenerate
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) pin_out <= 8'h00;
		else pin_out <= pin_d;
	end
endmodule // wfo_pin_mux

// ===== wfo_pkg.sv
// Purpose: Types shared by the fault override block.
// Assumes: Constants live in wfo_regs.svh.
// Notes: Holds only types.
package wfo_pkg;
	typedef enum logic [1:0] {
		WAVE_PLAIN,
		WAVE_COMMON,
		WAVE_PATTERN
	} wave_mode_t;
	typedef enum logic [1:0] {
		PROT_RUN,
		PROT_TRIPPED,
		PROT_WAIT_UPDATE
	} prot_state_t;
endpackage

// ===== wfo_power_stage.sv
// Purpose: Behavioural power stage switch pairs fed by the output pins.
// Assumes: One switch per pin; a switch follows its gate drive one clock later.
// Notes: No dead time of its own, so it only reports what it was driven with.
`timescale 1ns/10ps
module wfo_power_stage (
	// Clock
	input  wire logic       mclk_in,
	// Gate drive
	input  wire logic [7:0] gate_in,
	// Switch states
	output logic      [7:0] sw_out
);
	always_ff @(posedge mclk_in) begin
		sw_out <= gate_in;
	end
endmodule // wfo_power_stage

// ===== wfo_regs.svh
// Purpose: Offsets, field positions and reset values of the fault override block.
// Assumes: 8-bit register port, word index addressing.
// Notes: Definitions only.
`ifndef WFO_REGS_SVH
`define WFO_REGS_SVH
`define WFO_ADDR_W        4
`define WFO_CTRL_ADDR     4'h0
`define WFO_OVEN_ADDR     4'h1
`define WFO_DTIEN_ADDR    4'h2
`define WFO_LSBUF_ADDR    4'h3
`define WFO_STAT_ADDR     4'h4
`define WFO_INTEN_ADDR    4'h5
`define WFO_INTCLR_ADDR   4'h6
`define WFO_LIVE_ADDR     4'h7
`define WFO_CTRL_RST      8'h00
`define WFO_OVEN_RST      8'h00
`define WFO_DTIEN_RST     8'h00
`define WFO_LSBUF_RST     8'h00
`define WFO_CTRL_PGM_BIT  0
`define WFO_CTRL_COMMON_WAVEFORM_CHANNEL_MODE_BIT 1
`define WFO_CTRL_CBC_BIT  2
`define WFO_CTRL_FEN_BIT  3
`define WFO_ST_FAULT_BIT  0
`define WFO_ST_REST_BIT   1
`define WFO_ST_UNMAP_BIT  2
`define WFO_NCH           4
`endif

// ===== wfo_restore_sel.sv
// Purpose: Computes the override set restored after a fault.
// Assumes: Each dead-time channel drives a high/low pin pair.
// Notes: Combinational.
`timescale 1ns/10ps
`include "wfo_regs.svh"
module wfo_restore_sel (
	// Configuration
	input  wire wfo_pkg::wave_mode_t       mode_in,
	input  wire logic [`WFO_NCH-1:0]       dti_en_in,
	input  wire logic [7:0]                lsbuf_in,
	// Result
	output logic      [7:0]                restore_out
);
	logic [7:0] from_dti;
	genvar g;
	generate
		for (g = 0; g < `WFO_NCH; g++) begin : g_ch
			assign from_dti[2*g]   = dti_en_in[g];
			assign from_dti[2*g+1] = dti_en_in[g];
		end
	endgenerate
	// Pattern mode restores from the low-side buffer.
	assign restore_out = (mode_in == wfo_pkg::WAVE_PATTERN) ? lsbuf_in : from_dti;
endmodule // wfo_restore_sel
